// ### hw/sacc_cfg.svh
// Purpose: Timing counts and widths for the converter control block.
// Assumes: core_clk runs at 50 MHz.
// Notes: Counts derive from printed times; least times round up.
`ifndef SACC_CFG_SVH
`define SACC_CFG_SVH
`define SACC_CLK_PERIOD_NS 20
`define SACC_RES_BITS 12
`define SACC_CONV_CYCLES_12 14
`define SACC_CONV_CYCLES_10 12
`define SACC_WAKE_NS 1000
`define SACC_WAKE_CYCLES ((`SACC_WAKE_NS + `SACC_CLK_PERIOD_NS - 1) / `SACC_CLK_PERIOD_NS)
`define SACC_ACQ_NS 140
`define SACC_ACQ_CYCLES ((`SACC_ACQ_NS + `SACC_CLK_PERIOD_NS - 1) / `SACC_CLK_PERIOD_NS)
// Read strobe hold: three cycles for the bus to turn on, two through the host's flops, one spare.
`define SACC_READ_CYCLES 6
`define SACC_PULSE_NS 15
`define SACC_PULSE_CYCLES 1
`define SACC_FULL_CODE 12'hfff
`endif

// ### hw/sacc_pkg.sv
// Purpose: Types shared by both ends of the converter link.
// Assumes: Nothing beyond the cfg header.
// Notes: Holds state enumerations only.
package sacc_pkg;
  // Device sequencer states.
  typedef enum logic [1:0] {
    SACC_TRACK = 2'b00,
    SACC_CONV = 2'b01,
    SACC_SLEEP = 2'b10,
    SACC_WAKE = 2'b11
  } sacc_dev_state_e;
  // Host sequencer states.
  typedef enum logic [2:0] {
    SACC_H_IDLE = 3'b000,
    SACC_H_LOW = 3'b001,
    SACC_H_WAIT = 3'b010,
    SACC_H_READ = 3'b011,
    SACC_H_ACQ = 3'b100
  } sacc_host_state_e;
endpackage

// ### hw/sacc_link_if.sv
// Purpose: Pins between the converter and its host.
// Assumes: Single clock core_clk shared by both ends.
// Notes: The result bus wire level is resolved here from the enable.
`timescale 1ns/10ps
`default_nettype none
`include "sacc_cfg.svh"
interface sacc_link_if;
  logic conversion_start_n;
  logic busy;
  logic cs_n;
  logic rd_n;
  logic [`SACC_RES_BITS-1:0] result_bus_o;
  logic result_bus_oe;
  wire [`SACC_RES_BITS-1:0] result_bus;
  // A released bus reads as zero, as with pull-downs; nobody may sample it then.
  assign result_bus = result_bus_oe ? result_bus_o : '0;
  modport dev (
    input conversion_start_n, cs_n, rd_n,
    output busy, result_bus_o, result_bus_oe
  );
  modport host (
    output conversion_start_n, cs_n, rd_n,
    input busy, result_bus
  );
endinterface
`default_nettype wire

// ### hw/sacc_dev.sv
// Purpose: Converter end: conversion sequencing and parallel result readout.
// Assumes: Pin inputs are asynchronous and pass two flip-flops first.
// Notes: The analog side is modelled by the sample_code input.
// Operation
// RQ1: Falling start edge samples, starts, raises busy.
// RQ2: Busy drops at conversion end; host interrupt.
// RQ3: Host reads with select and read together.
// RQ4: Result is unsigned straight binary code.
// RQ5: Host discards first conversion after power-up; sacc_host still delivers it, with res_dummy set.
// RQ6: Host keeps start input at defined level.
// RQ7: Track opens at end, closes at edge.
// RQ8: Drive result only while select, read low.
// RQ9: Release bus when select or read high.
// RQ10: Tied-low read shows result at busy fall.
// RQ11: Host never reads during a conversion.
// RQ12: Start level at end picks mode.
// RQ13: Host raises start before busy falls.
// RQ14: New falling edge during busy restarts.
// RQ15: Host waits 140 ns after busy falls.
// RQ16: Start still low at end means sleep.
// RQ17: Wake on rising edge after 1 us.
// RQ18: Busy rises only after start goes low.
// RQ19: System supplies a continuous master clock.
// RQ20: Conversion lasts 14 or 12 clocks.
// RQ21: Steps begin on first edge after busy.
// RQ22: Start pulse may be as short as 15 ns; here a pulse shorter than one clock may be missed.
// RQ23: After reset: tracking, busy low, bus released.
`timescale 1ns/10ps
`default_nettype none
`include "sacc_cfg.svh"
module sacc_dev
  import sacc_pkg::*;
#(
  parameter bit WIDE12 = 1'b1
) (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic nrst,
  // Analog model input.
  input wire logic [`SACC_RES_BITS-1:0] sample_code,
  // Link pins.
  sacc_link_if.dev link,
  // Status.
  output logic asleep,
  output logic tracking
);
  // *****************************************************************
  // Input synchronisers
  // *****************************************************************
  logic start_m_q, start_s_q, start_p_q;
  logic cs_m_q, cs_s_q, rd_m_q, rd_s_q;
  // Two flops per pin, a third on start for edges; the first stage never feeds logic.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      start_m_q <= 1'b1;
      start_s_q <= 1'b1;
      start_p_q <= 1'b1;
      cs_m_q <= 1'b1;
      cs_s_q <= 1'b1;
      rd_m_q <= 1'b1;
      rd_s_q <= 1'b1;
    end else begin
      start_m_q <= link.conversion_start_n;
      start_s_q <= start_m_q;
      start_p_q <= start_s_q;
      cs_m_q <= link.cs_n;
      cs_s_q <= cs_m_q;
      rd_m_q <= link.rd_n;
      rd_s_q <= rd_m_q;
    end
  end
  // Edges come from the synchronised copies, so a pin pulse shorter than one
  // clock may be missed; the host therefore holds start low a whole clock.
  logic start_fall, start_rise;
  assign start_fall = start_p_q && !start_s_q;
  assign start_rise = !start_p_q && start_s_q;

  // Conversion length for the chosen width.
  function automatic logic [4:0] conv_len(input bit wide);
    conv_len = wide ? 5'(`SACC_CONV_CYCLES_12) : 5'(`SACC_CONV_CYCLES_10);
  endfunction

  // Result code for the chosen width; the narrow variant keeps the top bits.
  function automatic logic [`SACC_RES_BITS-1:0] result_code(
    input logic [`SACC_RES_BITS-1:0] raw);
    result_code = WIDE12 ? raw : {2'b00, raw[`SACC_RES_BITS-1:2]};
  endfunction

  // *****************************************************************
  // Sequencer
  // *****************************************************************
  sacc_dev_state_e state_q;
  logic [4:0] step_q;
  logic [5:0] wake_q;
  logic wake_pend_q;
  logic [`SACC_RES_BITS-1:0] held_q, result_q;
  logic done;
  assign done = (state_q == SACC_CONV) && (step_q == conv_len(WIDE12) - 5'd1);
  // End of wake-up with a start low seen; busy rises at this very edge so the
  // busy pulse is as long after a wake-up as after a start from tracking.
  logic wake_go;
  assign wake_go = (state_q == SACC_WAKE) && (wake_q == 6'(`SACC_WAKE_CYCLES - 1))
    && (wake_pend_q || start_fall);

  // State moves; a short pulse is caught only if a clock edge samples it low.  see RQ22
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= SACC_TRACK; // see RQ23
    end else begin
      case (state_q)
        SACC_TRACK: if (start_fall) state_q <= SACC_CONV; // see RQ1 see RQ7
        SACC_CONV: begin
          if (start_fall) begin
            state_q <= SACC_CONV; // see RQ14
          end else if (done) begin
            state_q <= start_s_q ? SACC_TRACK : SACC_SLEEP; // see RQ12 see RQ16
          end
        end
        // A falling start while asleep is ignored; only a rising one wakes.
        SACC_SLEEP: if (start_rise) state_q <= SACC_WAKE; // see RQ17
        SACC_WAKE: begin
          // Busy waits for both the wake time and a low start.  see RQ18
          // A start that already rose and fell again is remembered meanwhile.
          if (wake_go) begin
            state_q <= SACC_CONV;
          end
        end
        default: state_q <= SACC_TRACK;
      endcase
    end
  end

  // Step counter restarts on every start, so an abort begins afresh.
  // It stands at zero outside conversion, ready for the first step.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      step_q <= 5'd0;
    end else if (start_fall || state_q != SACC_CONV) begin
      step_q <= 5'd0; // see RQ14 see RQ21
    end else if (!done) begin
      step_q <= step_q + 5'd1; // see RQ20
    end
  end

  // Wake-up timer and a memory of a start edge during wake-up.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      wake_q <= 6'd0;
      wake_pend_q <= 1'b0;
    end else if (state_q != SACC_WAKE) begin
      wake_q <= 6'd0;
      wake_pend_q <= 1'b0;
    end else begin
      if (wake_q != 6'(`SACC_WAKE_CYCLES - 1)) wake_q <= wake_q + 6'd1; // see RQ17
      if (start_fall) wake_pend_q <= 1'b1; // see RQ18
    end
  end

  // Sample is held at the start edge; result lands at the end.
  // The held code models the track-and-hold; a restart takes a fresh sample.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      held_q <= '0;
      result_q <= '0;
    end else begin
      if (start_fall && state_q != SACC_SLEEP) held_q <= sample_code; // see RQ1
      // Narrow variant keeps only the top bits as an unsigned code.  see RQ4
      if (done && !start_fall) begin
        result_q <= result_code(held_q);
      end
    end
  end

  // *****************************************************************
  // Outputs
  // *****************************************************************
  // Busy is high in conversion; drops with the result stored.  see RQ2
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      link.busy <= 1'b0;
      asleep <= 1'b0;
      tracking <= 1'b1;
    end else begin
      // A restart on the last step keeps busy high; the end of wake-up raises it.
      link.busy <= (state_q == SACC_CONV && (!done || start_fall)) || wake_go
        || start_fall && state_q == SACC_TRACK;
      asleep <= (state_q == SACC_SLEEP);
      // Tracking follows SACC_TRACK one clock late; a restart or a start in wake-up also takes a sample.
      tracking <= (state_q == SACC_TRACK); // see RQ7
    end
  end

  // Bus drives only while both strobes are low; the result register is
  // copied in the same cycle busy drops, so a tied-low read sees it then.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      link.result_bus_oe <= 1'b0;
      link.result_bus_o <= '0;
    end else begin
      link.result_bus_oe <= !cs_s_q && !rd_s_q; // see RQ8 see RQ9
      link.result_bus_o <= (done && !start_fall) ? result_code(held_q) : result_q; // see RQ10
    end
  end
endmodule // sacc_dev
`default_nettype wire

// ### hw/sacc_host.sv
// Purpose: Host end: issues starts, waits for busy, reads results.
// Assumes: Device shares core_clk; pins from it still pass two flops.
// Notes: First result after reset is flagged as a dummy.
`timescale 1ns/10ps
`default_nettype none
`include "sacc_cfg.svh"
module sacc_host
  import sacc_pkg::*;
(
  // Clock and reset.
  input wire logic core_clk,
  input wire logic nrst,
  // User requests.
  input wire logic req_start,
  input wire logic req_sleep,
  // Link pins.
  sacc_link_if.host link,
  // Results.
  output logic [`SACC_RES_BITS-1:0] res_data,
  output logic res_valid,
  output logic res_dummy,
  output logic ready
);
  sacc_host_state_e state_q;
  logic busy_m_q, busy_s_q, busy_p_q;
  logic [`SACC_RES_BITS-1:0] bus_m_q, bus_s_q;
  logic [3:0] cnt_q;
  logic first_q, sleep_q;
  logic busy_fall;
  assign busy_fall = busy_p_q && !busy_s_q; // see RQ2

  // Synchronisers for busy and the result bus.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      busy_m_q <= 1'b0;
      busy_s_q <= 1'b0;
      busy_p_q <= 1'b0;
      bus_m_q <= '0;
      bus_s_q <= '0;
    end else begin
      busy_m_q <= link.busy;
      busy_s_q <= busy_m_q;
      busy_p_q <= busy_s_q;
      bus_m_q <= link.result_bus;
      bus_s_q <= bus_m_q;
    end
  end

  // Host sequence; start pin idles high, never floating.  see RQ6 see RQ19
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= SACC_H_IDLE;
      link.conversion_start_n <= 1'b1;
      link.cs_n <= 1'b1;
      link.rd_n <= 1'b1;
      cnt_q <= 4'd0;
      sleep_q <= 1'b0;
    end else begin
      case (state_q)
        SACC_H_IDLE: if (req_start) begin
          link.conversion_start_n <= 1'b0;
          sleep_q <= req_sleep;
          cnt_q <= 4'd0;
          state_q <= SACC_H_LOW;
        end
        SACC_H_LOW: begin
          // Pulse of one or more cycles exceeds the least width.  see RQ22
          // In fast mode start returns high well before busy falls.  see RQ13
          if (!sleep_q) link.conversion_start_n <= 1'b1;
          state_q <= SACC_H_WAIT;
        end
        SACC_H_WAIT: if (busy_fall) begin
          // Strobes only after busy drops.  see RQ11 see RQ3
          link.cs_n <= 1'b0;
          link.rd_n <= 1'b0;
          cnt_q <= 4'd0;
          state_q <= SACC_H_READ;
        end
        SACC_H_READ: begin
          // Strobes stand until the driven bus has passed the input flops.
          cnt_q <= cnt_q + 4'd1;
          if (cnt_q == 4'(`SACC_READ_CYCLES)) begin
            link.cs_n <= 1'b1;
            link.rd_n <= 1'b1;
            link.conversion_start_n <= 1'b1; // Wakes the device if asleep.
            cnt_q <= 4'd0;
            state_q <= SACC_H_ACQ;
          end
        end
        SACC_H_ACQ: begin
          // Acquisition spacing after busy falls.  see RQ15
          cnt_q <= cnt_q + 4'd1;
          if (cnt_q == 4'(`SACC_ACQ_CYCLES)) state_q <= SACC_H_IDLE;
        end
        default: state_q <= SACC_H_IDLE;
      endcase
    end
  end

  // Result capture; the first after reset is marked dummy.  see RQ5
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      res_data <= '0;
      res_valid <= 1'b0;
      res_dummy <= 1'b0;
      first_q <= 1'b1;
      ready <= 1'b0;
    end else begin
      res_valid <= 1'b0;
      ready <= (state_q == SACC_H_IDLE);
      if (state_q == SACC_H_READ && cnt_q == 4'(`SACC_READ_CYCLES)) begin
        res_data <= bus_s_q;
        res_valid <= 1'b1;
        res_dummy <= first_q;
        first_q <= 1'b0;
      end
    end
  end
endmodule // sacc_host
`default_nettype wire

// ### testbench/sacc_link_props.sv
// Purpose: Concurrent checks on the pins between converter and host.
// Assumes: One clock domain, core_clk, with nrst as its reset.
// Notes: Helper counters stand in for long repetitions.
`timescale 1ns/10ps
`default_nettype none
`include "sacc_cfg.svh"
module sacc_link_props #(
  parameter int CONV = `SACC_CONV_CYCLES_12,
  parameter int WAKE = `SACC_WAKE_CYCLES
) (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic nrst,
  // Link pins.
  input wire logic conversion_start_n,
  input wire logic busy,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic [`SACC_RES_BITS-1:0] result_bus_o,
  input wire logic result_bus_oe
);
  // ****************************************
  // Helper logic
  // ****************************************
  logic [7:0] busy_cnt_q;
  logic [7:0] wake_cnt_q;
  logic [7:0] lo_age_q;
  logic slept_q;
  logic waking_q;
  logic low_in_wake_q;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  // Cycles busy has stood high; a restart only makes it longer.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) busy_cnt_q <= 8'h00;
    else busy_cnt_q <= busy ? busy_cnt_q + 8'h01 : 8'h00;
  end
  // Cycles since start was last seen low, saturating.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) lo_age_q <= 8'hff;
    else if (!conversion_start_n) lo_age_q <= 8'h00;
    else if (lo_age_q != 8'hff) lo_age_q <= lo_age_q + 8'h01;
  end
  // Sleep is inferred from the pins, since the checker cannot see the state.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) slept_q <= 1'b0;
    else if ($fell(busy) && !conversion_start_n) slept_q <= 1'b1;
    else if ($rose(conversion_start_n)) slept_q <= 1'b0;
  end
  // Wake-up window, counted from the pin edge.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) waking_q <= 1'b0;
    else if ($rose(conversion_start_n) && slept_q) waking_q <= 1'b1;
    else if (busy) waking_q <= 1'b0;
  end
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) wake_cnt_q <= 8'h00;
    else if (!waking_q) wake_cnt_q <= 8'h00;
    else if (wake_cnt_q != 8'hff) wake_cnt_q <= wake_cnt_q + 8'h01;
  end
  // A start low seen during wake-up may start the conversion much later.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) low_in_wake_q <= 1'b0;
    else if (!waking_q) low_in_wake_q <= 1'b0;
    else if (!conversion_start_n) low_in_wake_q <= 1'b1;
  end
  // ****************************************
  // Assertions
  // ****************************************
  a_oe_needs_strobes: assert property (
    result_bus_oe |-> !$past(cs_n, 3) && !$past(rd_n, 3))
    else $error("bus driven without select and read");
  a_oe_released: assert property (
    $past(cs_n, 3) || $past(rd_n, 3) |-> !result_bus_oe)
    else $error("bus not released after strobe rose");
  a_conv_length: assert property (
    $fell(busy) |-> busy_cnt_q >= CONV)
    else $error("busy pulse shorter than conversion");
  a_busy_cause: assert property (
    $rose(busy) |-> lo_age_q <= 8'h08 || low_in_wake_q)
    else $error("busy rose without a start low");
  a_wake_delay: assert property (
    $rose(busy) && waking_q |-> wake_cnt_q >= WAKE)
    else $error("busy rose before wake-up time");
  a_no_read_busy: assert property (
    busy |-> cs_n || rd_n)
    else $error("read during conversion");
  a_acq_gap: assert property (
    $fell(busy) |=> (!$fell(conversion_start_n)) [*7])
    else $error("start too soon after busy fell");
  a_data_steady: assert property (
    result_bus_oe && $past(result_bus_oe) |-> $stable(result_bus_o))
    else $error("bus data changed during read");
endmodule // sacc_link_props
`default_nettype wire

// ### testbench/tb_sar_adc_conversion_control.sv
// Purpose: Runs host and converter back to back and checks results.
// Assumes: 12-bit variant, 50 MHz core_clk.
// Notes: Inputs change on the falling edge only.
`timescale 1ns/10ps
`default_nettype none
`include "sacc_cfg.svh"
module tb_sar_adc_conversion_control;
  logic core_clk, nrst, req_start, req_sleep, res_valid, res_dummy, ready, asleep, tracking;
  logic [11:0] sample_code, res_data, nb;
  int num_errors, n_checks, cycles, k;
  logic [11:0] codes [6] = '{12'h000, `SACC_FULL_CODE, 12'ha5c, 12'h3c1, 12'h801, 12'h7ff};
  bit slp [6] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
  // ****************************************
  // Design and checker
  // ****************************************
  sacc_link_if sacc_link_if_i ();
  sacc_dev #(.WIDE12(1'b1)) sacc_dev_i (.core_clk(core_clk), .nrst(nrst),
    .sample_code(sample_code), .link(sacc_link_if_i.dev), .asleep(asleep), .tracking(tracking));
  sacc_host sacc_host_i (.core_clk(core_clk), .nrst(nrst), .req_start(req_start),
    .req_sleep(req_sleep), .link(sacc_link_if_i.host), .res_data(res_data),
    .res_valid(res_valid), .res_dummy(res_dummy), .ready(ready));
  sacc_link_props #(.CONV(`SACC_CONV_CYCLES_12), .WAKE(`SACC_WAKE_CYCLES)) sacc_link_props_i (
    .core_clk(core_clk), .nrst(nrst), .conversion_start_n(sacc_link_if_i.conversion_start_n),
    .busy(sacc_link_if_i.busy), .cs_n(sacc_link_if_i.cs_n), .rd_n(sacc_link_if_i.rd_n),
    .result_bus_o(sacc_link_if_i.result_bus_o), .result_bus_oe(sacc_link_if_i.result_bus_oe));
  // ****************************************
  // Tasks
  // ****************************************
  // Four-state compare, so an unknown never passes.
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One conversion; returns how many cycles busy stood high.
  task automatic conv(input logic [11:0] code, input bit s, output logic [11:0] nbusy);
    int i;
    nbusy = 12'h000;
    @(negedge core_clk);
    for (i = 0; i < 400 && ready !== 1'b1; i++) @(negedge core_clk);
    sample_code = code;
    req_sleep = s;
    req_start = 1'b1;
    for (i = 0; i < 400 && ready === 1'b1; i++) @(negedge core_clk);
    req_start = 1'b0;
    for (i = 0; i < 400 && res_valid !== 1'b1; i++) begin
      @(negedge core_clk);
      if (sacc_link_if_i.busy === 1'b1) nbusy = nbusy + 12'h001;
    end
  endtask
  task tally_and_finish;
    $display("checks=%0d errors=%0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // ****************************************
  // Clock, timeout and sequence
  // ****************************************
  always #10 core_clk = ~core_clk;
  // A hang is cut short well past the expected few hundred cycles.
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      tally_and_finish;
    end
  end
  // Fast and sleep conversions mixed, so every mode change is crossed.
  initial begin
    core_clk = 1'b0;
    nrst = 1'b0;
    req_start = 1'b0;
    req_sleep = 1'b0;
    sample_code = 12'h000;
    repeat (16) @(posedge core_clk);
    @(negedge core_clk);
    nrst = 1'b1;
    chk({11'h000, sacc_link_if_i.busy}, 12'h000);
    chk({11'h000, tracking}, 12'h001);
    chk({11'h000, sacc_link_if_i.result_bus_oe}, 12'h000);
    for (k = 0; k < 6; k++) begin
      conv(codes[k], slp[k], nb);
      chk(res_data, codes[k]);
      chk({11'h000, res_dummy}, {11'h000, k == 0});
      chk(nb, 12'(`SACC_CONV_CYCLES_12));
      chk({11'h000, asleep}, {11'h000, slp[k]});
      chk({11'h000, tracking}, {11'h000, !slp[k]});
      repeat (4) @(negedge core_clk);
      chk({11'h000, sacc_link_if_i.result_bus_oe}, 12'h000);
    end
    tally_and_finish;
  end
endmodule // tb_sar_adc_conversion_control
`default_nettype wire
